// file: accel_control_register_bank.sv
// Purpose: Control register bank 0x14..0x23 with pointer, strap defaults and auto-sleep.
// Assumes: The serial front end runs on clk_i and hands over one byte per strobe.
// Notes:   Accesses before ready_o are ignored; soft reset reloads the defaults.
//
// Behaviour
// - Read-only state report at 0x14, strap default.
// - Range/selftest/reset/active register at 0x15, strap default.
// - Power, endian, increment, fast-read register at 0x16.
// - Rate and decimation register at 0x17, strap default.
// - Wake sources and pin setup at 0x18.
// - Axis skip and hibernate register at 0x19.
// - Twelve-bit wake idle time at 0x1A/0x1B.
// - Twelve-bit sleep idle time at 0x1C/0x1D.
// - Inactivity count reached enters automatic sleep.
// - Interrupt enable 0x20 and routing 0x21.
// - X and Y zero-g trims at 0x22/0x23.
// - Skipped axes bypassed during auto-increment.
`timescale 1ns/100ps
module accel_control_register_bank
   import accel_bank_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   // Boot strap pin, asynchronous.
   input  wire logic              boot_strap_pin_i,
   // Byte access port from the serial front end.
   input  wire logic              acc_start_i,
   input  wire logic [7:0]        acc_addr_i,
   input  wire logic              acc_wr_i,
   input  wire logic [7:0]        acc_wdata_i,
   input  wire logic              acc_rd_i,
   output logic      [7:0]        rd_data_o,
   output logic                   rd_valid_o,
   output logic      [7:0]        pointer_o,
   output logic                   ready_o,
   // Sensor core state and activity.
   input  wire logic              core_upd_i,
   input  wire logic [1:0]        core_state_i,
   input  wire logic              gate_err_i,
   input  wire logic [4:0]        gate_cnt_i,
   input  wire logic              sample_tick_i,
   input  wire logic              activity_i,
   output logic                   auto_sleep_o,
   // Configuration towards the sensor core.
   output logic      [7:0]        operating_state_report_o,
   output logic      [7:0]        range_selftest_o,
   output logic      [7:0]        power_endian_o,
   output logic      [7:0]        rate_decimation_o,
   output logic      [7:0]        wake_sources_pins_o,
   output logic      [7:0]        axis_skip_hibernate_o,
   output logic      [IDLE_W-1:0] wake_idle_o,
   output logic      [IDLE_W-1:0] sleep_idle_o,
   output logic      [IDLE_W-1:0] inactivity_timeout_o,
   output logic      [7:0]        irq_output_enable_o,
   output logic      [7:0]        irq_pin_routing_o,
   output logic      [7:0]        x_zero_g_trim_o,
   output logic      [7:0]        y_zero_g_trim_o
);

   // Reset value of a bank register for a given strap level.
   function automatic logic [7:0] default_of(input logic [7:0] a, input logic strap);
      logic [7:0] v;
      v = DEF_ZERO;
      if (a == ADDR_REPORT && strap) v = DEF_REPORT_HI;
      if (a == ADDR_CFG1 && strap) v = DEF_CFG1_HI;
      if (a == ADDR_CFG3 && strap) v = DEF_CFG3_HI;
      if (a == ADDR_CFG4) v = DEF_CFG4;
      if (a == ADDR_IRQ_EN && strap) v = DEF_IRQ_EN_HI;
      return v;
   endfunction

   // True for addresses held in the writable part of the bank.
   function automatic logic in_cfg(input logic [7:0] a);
      return (a >= ADDR_CFG1) && (a <= ADDR_Y_TRIM);
   endfunction

   // Next pointer value. Inside the output data block the pointer walks the
   // axes in X, Y, Z order, skips axes marked skipped and wraps to the block
   // start; in fast-read mode only the leading byte of each axis is visited.
   function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast,
                                            input logic [2:0] skip);
      logic [7:0] r;
      logic [1:0] axis;
      logic [1:0] cand;
      logic       found;
      r     = a + 8'h01;
      axis  = 2'b00;
      cand  = 2'b00;
      found = 1'b0;
      if (a >= ADDR_DATA_FIRST && a <= ADDR_DATA_LAST) begin
         axis = 2'((a - ADDR_DATA_FIRST) >> 1);
         if (!fast && !a[0]) begin
            r = a + 8'h01;
         end else begin
            r = a;
            for (int i = 1; i <= 3; i++) begin
               cand = 2'((int'(axis) + i) % 3);
               if (!found && !skip[cand]) begin
                  r     = ADDR_DATA_FIRST + {5'h00, cand, 1'b0};
                  found = 1'b1;
               end
            end
         end
      end
      return r;
   endfunction

   // Strap synchroniser; only the second stage is read by logic.
   logic        strap_meta;
   logic        strap_sync;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= boot_strap_pin_i;
         strap_sync <= strap_meta;
      end
   end

   // Register storage.
   logic [7:0]  cfg_mem [ADDR_CFG1:ADDR_Y_TRIM];
   logic [7:0]  report;
   logic [7:0]  ptr;
   boot_phase_t phase;
   logic        fast_rd;
   logic [2:0]  skip_bits;
   logic        take_byte;
   logic        soft_rst;

   assign fast_rd   = cfg_mem[ADDR_CFG2][BIT_FAST_READ];
   assign skip_bits = {cfg_mem[ADDR_CFG5][BIT_Z_SKIP], cfg_mem[ADDR_CFG5][BIT_Y_SKIP],
                       cfg_mem[ADDR_CFG5][BIT_X_SKIP]};
   assign take_byte = (phase == PH_RUN) && !acc_start_i && (acc_wr_i || acc_rd_i);
   assign soft_rst  = take_byte && acc_wr_i && (ptr == ADDR_CFG1) && acc_wdata_i[BIT_SOFT_RESET];

   // Start-up sequence. The strap is only trusted once it has crossed both
   // synchroniser stages, so defaults are applied on the third edge after release.
   // A soft reset re-enters the load phase and samples the strap again.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase   <= PH_SYNC;
         ready_o <= 1'b0;
      end else begin
         unique case (phase)
            PH_SYNC:   phase <= PH_SETTLE;
            PH_SETTLE: phase <= PH_LOAD;
            PH_LOAD:   phase <= PH_RUN;
            PH_RUN:    phase <= soft_rst ? PH_LOAD : PH_RUN;
         endcase
         // Kept as its own flop so the port never carries decode glitches.
         ready_o <= (phase == PH_LOAD) || ((phase == PH_RUN) && !soft_rst);
      end
   end

   // Configuration registers: defaults on load, byte writes at the pointer.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int a = int'(ADDR_CFG1); a <= int'(ADDR_Y_TRIM); a++) begin
            cfg_mem[a] <= DEF_ZERO;
         end
         // Only the wake source register has a nonzero value with the strap low.
         cfg_mem[ADDR_CFG4] <= DEF_CFG4;
      end else if (phase == PH_LOAD) begin
         for (int a = int'(ADDR_CFG1); a <= int'(ADDR_Y_TRIM); a++) begin
            cfg_mem[a] <= default_of(8'(a), strap_sync);
         end
      end else if (take_byte && acc_wr_i && in_cfg(ptr) && !soft_rst) begin
         cfg_mem[ptr] <= acc_wdata_i;
      end
   end

   // State report follows the core; host writes never reach it.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         report <= DEF_ZERO;
      end else if (phase == PH_LOAD) begin
         report <= default_of(ADDR_REPORT, strap_sync);
      end else if (core_upd_i) begin
         report                                    <= DEF_ZERO;
         report[REP_STATE_LSB +: 2]                <= core_state_i;
         report[REP_CNT_LSB +: 5]                  <= gate_cnt_i;
         report[REP_ERR_BIT]                       <= gate_err_i;
      end
   end

   // Address pointer: loaded by a start, advanced after every byte.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ptr <= DEF_ZERO;
      end else if (phase == PH_RUN && acc_start_i) begin
         ptr <= acc_addr_i;
      end else if (take_byte) begin
         ptr <= next_addr(ptr, fast_rd, skip_bits);
      end
   end

   // Read data; addresses outside the bank read as zero.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_o  <= DEF_ZERO;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= take_byte && acc_rd_i && !acc_wr_i;
         if (take_byte && acc_rd_i && !acc_wr_i) begin
            if (ptr == ADDR_REPORT) begin
               rd_data_o <= report;
            end else if (in_cfg(ptr)) begin
               rd_data_o <= cfg_mem[ptr];
            end else begin
               rd_data_o <= DEF_ZERO;
            end
         end
      end
   end

   // Inactivity counter for automatic sleep. Samples without activity are
   // counted while active; the host must load a nonzero low byte, otherwise
   // the feature stays off and the core remains awake.
   logic [IDLE_W-1:0] inact_cnt;
   logic [IDLE_W-1:0] aslp_limit;
   logic              aslp_on;
   assign aslp_limit = {cfg_mem[ADDR_ASLP_HI][HI_NIBBLE_W-1:0], cfg_mem[ADDR_ASLP_LO]};
   assign aslp_on    = (cfg_mem[ADDR_ASLP_LO] != DEF_ZERO) && cfg_mem[ADDR_CFG1][BIT_ACTIVE];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         inact_cnt    <= '0;
         auto_sleep_o <= 1'b0;
      end else if (!aslp_on || phase != PH_RUN) begin
         inact_cnt    <= '0;
         auto_sleep_o <= 1'b0;
      end else if (sample_tick_i) begin
         if (activity_i) begin
            inact_cnt    <= '0;
            auto_sleep_o <= 1'b0;
         end else if (!auto_sleep_o) begin
            inact_cnt <= inact_cnt + 12'h001;
            if (inact_cnt + 12'h001 >= aslp_limit) begin
               auto_sleep_o <= 1'b1;
            end
         end
      end
   end

   // Status and configuration views, all taken from flip-flops.
   assign pointer_o                = ptr;
   assign operating_state_report_o = report;
   assign range_selftest_o         = cfg_mem[ADDR_CFG1];
   assign power_endian_o           = cfg_mem[ADDR_CFG2];
   assign rate_decimation_o        = cfg_mem[ADDR_CFG3];
   assign wake_sources_pins_o      = cfg_mem[ADDR_CFG4];
   assign axis_skip_hibernate_o    = cfg_mem[ADDR_CFG5];
   assign wake_idle_o              = {cfg_mem[ADDR_WAKE_HI][HI_NIBBLE_W-1:0], cfg_mem[ADDR_WAKE_LO]};
   assign sleep_idle_o             = {cfg_mem[ADDR_SLEEP_HI][HI_NIBBLE_W-1:0], cfg_mem[ADDR_SLEEP_LO]};
   assign inactivity_timeout_o     = aslp_limit;
   assign irq_output_enable_o      = cfg_mem[ADDR_IRQ_EN];
   assign irq_pin_routing_o        = cfg_mem[ADDR_IRQ_ROUTE];
   assign x_zero_g_trim_o          = cfg_mem[ADDR_X_TRIM];
   assign y_zero_g_trim_o          = cfg_mem[ADDR_Y_TRIM];

   // Checks on the documented behaviour.
   a_report_ro_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_wr_i && ptr == ADDR_REPORT && !core_upd_i) |=> $stable(report))
      else $error("State report changed by a host write.");

   a_cfg1_strap_default: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_LOAD) |=> (range_selftest_o == ($past(strap_sync) ? DEF_CFG1_HI : DEF_ZERO)))
      else $error("Range register default wrong for strap.");

   a_cfg2_zero_default: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_LOAD) |=> (power_endian_o == DEF_ZERO) && ready_o)
      else $error("Power register default not zero.");

   a_cfg3_strap_default: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_LOAD && strap_sync) |=> (rate_decimation_o == DEF_CFG3_HI))
      else $error("Rate register default wrong.");

   a_cfg4_default_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_LOAD) |=> (wake_sources_pins_o == DEF_CFG4))
      else $error("Wake source register default wrong.");

   a_cfg5_write_lands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_wr_i && ptr == ADDR_CFG5) |=> (axis_skip_hibernate_o == $past(acc_wdata_i)))
      else $error("Axis skip register write lost.");

   a_wake_idle_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_wr_i && ptr == ADDR_WAKE_HI)
      |=> (wake_idle_o[IDLE_W-1:8] == $past(acc_wdata_i[HI_NIBBLE_W-1:0])))
      else $error("Wake idle high nibble wrong.");

   a_sleep_idle_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_wr_i && ptr == ADDR_SLEEP_LO) |=> (sleep_idle_o[7:0] == $past(acc_wdata_i)))
      else $error("Sleep idle low byte wrong.");

   a_sleep_on_limit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_RUN && aslp_on && sample_tick_i && !activity_i && !auto_sleep_o
       && inact_cnt + 12'h001 >= aslp_limit && !soft_rst) |=> auto_sleep_o)
      else $error("Automatic sleep not entered at limit.");

   a_no_sleep_zero_lo: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (cfg_mem[ADDR_ASLP_LO] == DEF_ZERO) |=> !auto_sleep_o)
      else $error("Automatic sleep with zero timeout low byte.");

   a_irq_en_default: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_LOAD) |=> (irq_output_enable_o == ($past(strap_sync) ? DEF_IRQ_EN_HI : DEF_ZERO))
      && (irq_pin_routing_o == DEF_ZERO))
      else $error("Interrupt enable default wrong.");

   a_y_trim_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_wr_i && ptr == ADDR_Y_TRIM) |=> (y_zero_g_trim_o == $past(acc_wdata_i)))
      else $error("Y trim write lost.");

   a_skip_x_axis: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && ptr == ADDR_DATA_LAST && skip_bits == 3'b001) |=> (ptr == ADDR_DATA_FIRST + 8'h02))
      else $error("Skipped axis not bypassed.");

   a_ptr_increment: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && ptr >= ADDR_REPORT && ptr < ADDR_Y_TRIM) |=> (ptr == $past(ptr) + 8'h01))
      else $error("Pointer did not advance by one.");

   a_soft_reset_ready: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      soft_rst |=> !ready_o ##1 ready_o)
      else $error("Bank not reopened one cycle after soft reset.");

   a_read_answer: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_rd_i && !acc_wr_i && ptr == ADDR_REPORT)
      |=> rd_valid_o && (rd_data_o == $past(report)))
      else $error("State report read answered wrongly.");

   a_x_trim_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && acc_wr_i && ptr == ADDR_X_TRIM) |=> (x_zero_g_trim_o == $past(acc_wdata_i)))
      else $error("X trim write lost.");

   a_fast_skip_leap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (take_byte && fast_rd && ptr == ADDR_DATA_LAST - 8'h01 && skip_bits == 3'h1)
      |=> (ptr == ADDR_DATA_FIRST + 8'h02))
      else $error("Fast read did not leap over the skipped axis.");

   a_sleep_wakes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (phase == PH_RUN && aslp_on && sample_tick_i && activity_i) |=> !auto_sleep_o)
      else $error("Activity did not end automatic sleep.");

endmodule

// file: accel_bank_pkg.sv
// Purpose: Shared constants for the accelerometer control register bank.
// Assumes: Byte-wide registers reached through an auto-incrementing pointer.
// Notes:   Field positions of single control bits are gathered here.
package accel_bank_pkg;

   // Register addresses of the bank and of the neighbouring output data block.
   localparam logic [7:0] ADDR_REPORT     = 8'h14;
   localparam logic [7:0] ADDR_CFG1       = 8'h15;
   localparam logic [7:0] ADDR_CFG2       = 8'h16;
   localparam logic [7:0] ADDR_CFG3       = 8'h17;
   localparam logic [7:0] ADDR_CFG4       = 8'h18;
   localparam logic [7:0] ADDR_CFG5       = 8'h19;
   localparam logic [7:0] ADDR_WAKE_LO    = 8'h1A;
   localparam logic [7:0] ADDR_WAKE_HI    = 8'h1B;
   localparam logic [7:0] ADDR_SLEEP_LO   = 8'h1C;
   localparam logic [7:0] ADDR_SLEEP_HI   = 8'h1D;
   localparam logic [7:0] ADDR_ASLP_LO    = 8'h1E;
   localparam logic [7:0] ADDR_ASLP_HI    = 8'h1F;
   localparam logic [7:0] ADDR_IRQ_EN     = 8'h20;
   localparam logic [7:0] ADDR_IRQ_ROUTE  = 8'h21;
   localparam logic [7:0] ADDR_X_TRIM     = 8'h22;
   localparam logic [7:0] ADDR_Y_TRIM     = 8'h23;
   localparam logic [7:0] ADDR_DATA_FIRST = 8'h0C;
   localparam logic [7:0] ADDR_DATA_LAST  = 8'h11;

   // Reset values; the _HI variants apply while the boot strap pin is high.
   localparam logic [7:0] DEF_ZERO        = 8'h00;
   localparam logic [7:0] DEF_REPORT_HI   = 8'h01;
   localparam logic [7:0] DEF_CFG1_HI     = 8'h03;
   localparam logic [7:0] DEF_CFG3_HI     = 8'hC0;
   localparam logic [7:0] DEF_CFG4        = 8'h01;
   localparam logic [7:0] DEF_IRQ_EN_HI   = 8'h20;

   // Single control bits inside the configuration registers.
   localparam int unsigned BIT_SOFT_RESET = 7;   // In sensor_setup_range_selftest.
   localparam int unsigned BIT_ACTIVE     = 0;   // In sensor_setup_range_selftest.
   localparam int unsigned BIT_FAST_READ  = 0;   // In sensor_setup_power_endian.
   localparam int unsigned BIT_X_SKIP     = 7;   // In sensor_setup_axis_skip_hibernate.
   localparam int unsigned BIT_Y_SKIP     = 6;
   localparam int unsigned BIT_Z_SKIP     = 5;

   // Field layout of the operating state report.
   localparam int unsigned REP_STATE_LSB  = 0;
   localparam int unsigned REP_CNT_LSB    = 2;
   localparam int unsigned REP_ERR_BIT    = 7;

   // Widths.
   localparam int unsigned IDLE_W         = 12;
   localparam int unsigned HI_NIBBLE_W    = 4;

   // Start-up phases: strap settling, default load, normal run.
   typedef enum logic [1:0] {
      PH_SYNC   = 2'b00,
      PH_SETTLE = 2'b01,
      PH_LOAD   = 2'b10,
      PH_RUN    = 2'b11
   } boot_phase_t;

endpackage

// file: accel_host_model.sv
// Purpose: Host side model that drives the byte access port of the control register bank.
// Assumes: One strobe per byte; strobes rise and fall by non-blocking assignment on clk_i.
// Notes:   Unqualified address and data lines carry the inverse of their last value.
`timescale 1ns/100ps
module accel_host_model (
   // Clock.
   input  wire logic       clk_i,
   // Byte access port towards the bank.
   output logic            acc_start_o,
   output logic [7:0]      acc_addr_o,
   output logic            acc_wr_o,
   output logic [7:0]      acc_wdata_o,
   output logic            acc_rd_o,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i
);
   // The port starts idle so nothing is taken before the bank is ready.
   initial begin
      acc_start_o = 1'b0;
      acc_addr_o  = 8'h00;
      acc_wr_o    = 1'b0;
      acc_wdata_o = 8'hFF;
      acc_rd_o    = 1'b0;
   end

   // Loads the pointer; the stale address is scrambled so a late sample shows up.
   task automatic set_ptr(input logic [7:0] a);
      @(posedge clk_i);
      acc_start_o <= 1'b1;
      acc_addr_o  <= a;
      @(posedge clk_i);
      acc_start_o <= 1'b0;
      acc_addr_o  <= ~a;
   endtask

   // Writes one byte at the pointer.
   task automatic put_byte(input logic [7:0] d);
      @(posedge clk_i);
      acc_wr_o    <= 1'b1;
      acc_wdata_o <= d;
      @(posedge clk_i);
      acc_wr_o    <= 1'b0;
      acc_wdata_o <= ~d;
      // Let the write settle so callers see the updated registers.
      #1;
   endtask

   // Reads one byte at the pointer and waits a bounded time for the answer.
   task automatic get_byte(output logic [7:0] d, output logic ok);
      int n;
      @(posedge clk_i);
      acc_rd_o <= 1'b1;
      @(posedge clk_i);
      acc_rd_o <= 1'b0;
      ok = 1'b0;
      d  = 8'h00;
      for (n = 0; n < 3 && !ok; n++) begin
         #1;
         if (rd_valid_i === 1'b1) begin
            ok = 1'b1;
            d  = rd_data_i;
         end else begin
            @(posedge clk_i);
         end
      end
   endtask
endmodule

// file: test_accel_control_register_bank.sv
// Purpose: Self-checking bench for the accelerometer control register bank.
// Assumes: The host model issues every access; core inputs are driven here.
// Notes:   Both strap levels, soft reset, pointer walk and auto-sleep are exercised.
`timescale 1ns/100ps
module test_accel_control_register_bank;
   import accel_bank_pkg::*;
   logic clk_i, arst_n_i, strap, start, wr, rd, rd_valid, ready, upd, gerr, tick, act, asleep;
   logic [7:0] addr, wdata, rd_data, ptr, rep, cfg1, cfg3, irq_en, route, xtrim, d;
   logic [7:0] pend, wsrc, askip, ytrim;
   logic [4:0] gcnt;
   logic [1:0] cstate;
   logic [IDLE_W-1:0] widle, sidle, tmo;
   logic ok;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int i;
   logic [7:0] skip_tab [4][3] = '{'{8'h80, 8'h11, 8'h0E}, '{8'h00, 8'h11, 8'h0C},
                                   '{8'h40, 8'h0D, 8'h10}, '{8'h20, 8'h0F, 8'h0C}};

   accel_control_register_bank dut_u (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .boot_strap_pin_i(strap),
      .acc_start_i(start), .acc_addr_i(addr), .acc_wr_i(wr), .acc_wdata_i(wdata), .acc_rd_i(rd),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .pointer_o(ptr), .ready_o(ready),
      .core_upd_i(upd), .core_state_i(cstate), .gate_err_i(gerr), .gate_cnt_i(gcnt),
      .sample_tick_i(tick), .activity_i(act), .auto_sleep_o(asleep),
      .operating_state_report_o(rep), .range_selftest_o(cfg1), .power_endian_o(pend),
      .rate_decimation_o(cfg3), .wake_sources_pins_o(wsrc), .axis_skip_hibernate_o(askip),
      .wake_idle_o(widle), .sleep_idle_o(sidle), .inactivity_timeout_o(tmo),
      .irq_output_enable_o(irq_en), .irq_pin_routing_o(route), .x_zero_g_trim_o(xtrim),
      .y_zero_g_trim_o(ytrim));

   accel_host_model host_u (
      .clk_i(clk_i), .acc_start_o(start), .acc_addr_o(addr), .acc_wr_o(wr),
      .acc_wdata_o(wdata), .acc_rd_o(rd), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

   // Free-running 250 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // A hung handshake would otherwise stall the run forever.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end

   // Reset values per strap level, taken from the shared constants.
   function automatic logic [7:0] def_val(input logic [7:0] a, input logic s);
      case (a)
         ADDR_REPORT: def_val = s ? DEF_REPORT_HI : DEF_ZERO;
         ADDR_CFG1:   def_val = s ? DEF_CFG1_HI : DEF_ZERO;
         ADDR_CFG3:   def_val = s ? DEF_CFG3_HI : DEF_ZERO;
         ADDR_CFG4:   def_val = DEF_CFG4;
         ADDR_IRQ_EN: def_val = s ? DEF_IRQ_EN_HI : DEF_ZERO;
         default:     def_val = DEF_ZERO;
      endcase
   endfunction

   // Write pattern; soft reset and active bits stay clear, high bytes use four bits only.
   function automatic logic [7:0] pat(input logic [7:0] a);
      if (a == ADDR_CFG1) pat = 8'h5A;
      else if (a == ADDR_WAKE_HI || a == ADDR_SLEEP_HI || a == ADDR_ASLP_HI) pat = {4'h0, a[3:0] ^ 4'h9};
      else pat = {a[3:0], ~a[3:0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] exp);
      host_u.get_byte(d, ok);
      check(ok, 1'b1);
      check(d, exp);
   endtask

   // Reset for eight cycles with the strap settled, then wait for the bank to open.
   task automatic do_reset(input logic s);
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      strap    <= s;
      repeat (8) @(posedge clk_i);
      check(ready, 1'b0);
      arst_n_i <= 1'b1;
      for (i = 0; i < 6 && ready !== 1'b1; i++) @(posedge clk_i);
      check(ready, 1'b1);
   endtask

   // Burst read of the whole bank, checking data and pointer advance.
   task automatic read_all(input logic written, input logic s);
      int k;
      logic [7:0] a;
      host_u.set_ptr(ADDR_REPORT);
      for (k = 0; k < 16; k++) begin
         a = ADDR_REPORT + 8'(k);
         rd_chk((written && k > 0) ? pat(a) : def_val(a, s));
         if (k < 15) check(ptr, a + 8'h01);
      end
   endtask

   task automatic tick_once(input logic a);
      @(posedge clk_i);
      tick <= 1'b1;
      act  <= a;
      @(posedge clk_i);
      tick <= 1'b0;
      act  <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic summarize();
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence.
   initial begin
      {arst_n_i, strap, upd, gerr, tick, act, cstate, gcnt} = '0;
      do_reset(1'b0);
      read_all(1'b0, 1'b0);
      for (i = 0; i < 4; i++) begin
         host_u.set_ptr(ADDR_CFG5);
         host_u.put_byte(skip_tab[i][0]);
         host_u.set_ptr(skip_tab[i][1]);
         host_u.get_byte(d, ok);
         check(ptr, skip_tab[i][2]);
      end
      host_u.set_ptr(ADDR_REPORT);
      for (i = 0; i < 16; i++) host_u.put_byte(pat(ADDR_REPORT + 8'(i)));
      read_all(1'b1, 1'b0);
      // High byte patterns keep their upper nibble clear, so the pairs equal the 12-bit values.
      check(widle, {pat(ADDR_WAKE_HI), pat(ADDR_WAKE_LO)});
      check(sidle, {pat(ADDR_SLEEP_HI), pat(ADDR_SLEEP_LO)});
      check(tmo, {pat(ADDR_ASLP_HI), pat(ADDR_ASLP_LO)});
      check({route, xtrim}, {pat(ADDR_IRQ_ROUTE), pat(ADDR_X_TRIM)});
      check({pend, wsrc}, {pat(ADDR_CFG2), pat(ADDR_CFG4)});
      check({askip, ytrim}, {pat(ADDR_CFG5), pat(ADDR_Y_TRIM)});
      // Fast read is now on and X is skipped: from the Z low byte the pointer lands on Y low.
      host_u.set_ptr(ADDR_DATA_LAST - 8'h01);
      rd_chk(DEF_ZERO);
      check(ptr, ADDR_DATA_FIRST + 8'h02);
      // Core report load, then a write to it that must be dropped.
      @(posedge clk_i);
      {upd, cstate, gerr, gcnt} <= {1'b1, 2'b10, 1'b1, 5'h13};
      @(posedge clk_i);
      upd <= 1'b0;
      host_u.set_ptr(ADDR_REPORT);
      host_u.put_byte(8'hFF);
      check(ptr, ADDR_CFG1);
      host_u.set_ptr(ADDR_REPORT);
      rd_chk(8'hCE);
      host_u.set_ptr(8'h30);
      host_u.put_byte(8'h77);
      host_u.set_ptr(8'h30);
      rd_chk(8'h00);
      // Auto-sleep after three quiet samples; activity wakes it.
      host_u.set_ptr(ADDR_ASLP_LO);
      host_u.put_byte(8'h03);
      host_u.put_byte(8'h00);
      host_u.set_ptr(ADDR_CFG1);
      host_u.put_byte(8'h01);
      tick_once(1'b0);
      tick_once(1'b0);
      check(asleep, 1'b0);
      tick_once(1'b0);
      check(asleep, 1'b1);
      tick_once(1'b1);
      check(asleep, 1'b0);
      // Strap high defaults, then soft reset reloads them.
      do_reset(1'b1);
      read_all(1'b0, 1'b1);
      check({rep, cfg1, cfg3, irq_en}, {DEF_REPORT_HI, DEF_CFG1_HI, DEF_CFG3_HI, DEF_IRQ_EN_HI});
      host_u.set_ptr(ADDR_X_TRIM);
      host_u.put_byte(8'h3C);
      check(xtrim, 8'h3C);
      host_u.set_ptr(ADDR_CFG1);
      host_u.put_byte(8'h80);
      check(ready, 1'b0);
      repeat (2) @(posedge clk_i);
      for (i = 0; i < 6 && ready !== 1'b1; i++) @(posedge clk_i);
      #1;
      check({cfg1, xtrim}, {DEF_CFG1_HI, DEF_ZERO});
      summarize();
   end
endmodule
